// *** bench/spi_host_model.sv ***
// spi host model: drives serial clock, chip select and host data
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  input  wire logic i_clk,      // system clock, paces the link
  output logic      o_sclk,     // serial clock, still outside frames
  output logic      o_cs_low,   // chip select, active low
  output logic      o_mosi,     // host data line
  input  wire logic i_miso      // device data line as seen by host
);
  initial begin
    o_sclk   = 1'b0;
    o_cs_low = 1'b1;
    o_mosi   = 1'b0;
  end
  task automatic frame_begin();
    @(negedge i_clk);
    o_cs_low = 1'b0;
    repeat (10) @(negedge i_clk);
  endtask
  // released line shows the inverse of its last value
  task automatic frame_end();
    repeat (10) @(negedge i_clk);
    o_cs_low = 1'b1;
    o_mosi   = ~o_mosi;
    repeat (10) @(negedge i_clk);
  endtask
  // 160 ns serial period, data changes while sclk low
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_sclk = 1'b0;
      o_mosi = tx[i];
      repeat (10) @(negedge i_clk);
      o_sclk = 1'b1;
      rx[i]  = i_miso;
      repeat (10) @(negedge i_clk);
    end
    o_sclk = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** bench/spi_register_command_slave_test.sv ***
// self-checking bench for the spi register command slave
`timescale 1ns/100ps
`default_nettype none
module spi_register_command_slave_test;
  logic        i_clk, i_rst, sclk, cs_low, mosi, miso, sdio_wire, three, wr_ready, seen_ovr, seen_oe3;
  logic        sdo, sdo_oe, sdio_o, sdio_oe, wr_valid, rd_req, ovr;
  logic  [7:0] wr_addr, wr_data, rd_addr, rd_data, pointer, rx;
  logic  [7:0] mem [256];
  logic [15:0] wlog [$];
  int          n_errors, comparisons;

  // ==========================================
  // clock, wiring, register file side
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  assign sdio_wire = sdio_oe ? sdio_o : mosi;
  assign miso      = three ? sdio_wire : (sdo_oe ? sdo : 1'b1);
  always @(posedge i_clk) begin
    if (wr_valid && wr_ready) begin
      mem[wr_addr] <= wr_data;
      wlog.push_back({wr_addr, wr_data});
    end
    if (ovr) begin
      seen_ovr <= 1'b1;
    end
    if (sdo_oe && three) begin
      seen_oe3 <= 1'b1;
    end
  end
  always @(negedge i_clk) begin
    rd_data <= mem[rd_addr];
  end

  spi_host_model host (.i_clk(i_clk), .o_sclk(sclk), .o_cs_low(cs_low), .o_mosi(mosi), .i_miso(miso));
  spi_register_command_slave uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_chip_select_low(cs_low), .i_sdi(mosi),
    .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_sdio(sdio_wire), .o_sdio(sdio_o), .o_sdio_oe(sdio_oe),
    .i_three_wire_select(three), .o_wr_valid(wr_valid), .i_wr_ready(wr_ready), .o_wr_addr(wr_addr),
    .o_wr_data(wr_data), .o_rd_req(rd_req), .o_rd_addr(rd_addr), .i_rd_data(rd_data),
    .o_pointer(pointer), .o_overrun(ovr));

  // ==========================================
  // shared tasks
  task automatic tally_and_finish();
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check8(input string what, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic expect_wr(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] w;
    for (int k = 0; k < 4000 && wlog.size() == 0; k++) @(negedge i_clk);
    if (wlog.size() == 0) begin
      n_errors++;
      $display("MISMATCH write expected %h %h seen none", a, d);
      tally_and_finish();
    end else begin
      w = wlog.pop_front();
      check8("wr_addr", a, w[15:8]);
      check8("wr_data", d, w[7:0]);
    end
  endtask
  task automatic cmd2(input logic [7:0] op, input logic [7:0] b);
    host.frame_begin();
    host.xfer(op, rx);
    host.xfer(b, rx);
    host.frame_end();
  endtask
  task automatic burst(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1, input logic [7:0] d2);
    host.frame_begin();
    host.xfer(8'hE0, rx);
    host.xfer(a, rx);
    host.xfer(d0, rx);
    host.xfer(d1, rx);
    host.xfer(d2, rx);
    host.frame_end();
  endtask

  // ==========================================
  // scenarios
  task automatic t_single();
    cmd2(8'h1F, 8'h5A);
    check8("pointer", 8'h5A, pointer);
    cmd2(8'h5F, 8'hC3);
    expect_wr(8'h5A, 8'hC3);
    cmd2(8'h9F, 8'h00);
    check8("read", 8'hC3, rx);
    check8("pointer", 8'h5A, pointer);
  endtask
  task automatic t_incr();
    cmd2(8'h00, 8'hFE);
    cmd2(8'h60, 8'h11);
    expect_wr(8'hFE, 8'h11);
    check8("pointer", 8'hFF, pointer);
    cmd2(8'h7F, 8'h22);
    expect_wr(8'hFF, 8'h22);
    check8("pointer", 8'h00, pointer);
    cmd2(8'h00, 8'hFE);
    cmd2(8'hA0, 8'h00);
    check8("read", 8'h11, rx);
    cmd2(8'hBF, 8'h00);
    check8("read", 8'h22, rx);
    check8("pointer", 8'h00, pointer);
  endtask
  task automatic t_burst();
    burst(8'hFE, 8'h33, 8'h44, 8'h55);
    expect_wr(8'hFE, 8'h33);
    expect_wr(8'hFF, 8'h44);
    expect_wr(8'h00, 8'h55);
    check8("pointer", 8'h01, pointer);
    cmd2(8'h00, 8'h10);
    check8("pointer", 8'h10, pointer);
    cmd2(8'h3F, 8'h77);
    cmd2(8'hE1, 8'h77);
    check8("pointer unknown op", 8'h10, pointer);
    check8("extra writes", 8'h00, 8'(wlog.size()));
  endtask
  task automatic t_stall();
    wr_ready = 1'b0;
    burst(8'h20, 8'hA1, 8'hA2, 8'hA3);
    check8("wr_valid held", 8'h01, {7'h00, wr_valid});
    check8("overrun", 8'h01, {7'h00, seen_ovr});
    wr_ready = 1'b1;
    expect_wr(8'h20, 8'hA1);
    expect_wr(8'h21, 8'hA2);
    repeat (20) @(negedge i_clk);
    check8("dropped word", 8'h00, 8'(wlog.size()));
  endtask
  task automatic t_three();
    three = 1'b1;
    repeat (5) @(negedge i_clk);
    cmd2(8'h00, 8'h5A);
    cmd2(8'h80, 8'h00);
    check8("read 3-wire", 8'hC3, rx);
    check8("sdo idle", 8'h00, {7'h00, seen_oe3});
    three = 1'b0;
  endtask

  initial begin
    i_rst    = 1'b1;
    three    = 1'b0;
    wr_ready = 1'b1;
    seen_ovr = 1'b0;
    seen_oe3 = 1'b0;
    for (int i = 0; i < 256; i++) mem[i] = ~8'(i);
    repeat (3) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    check8("pointer reset", 8'h00, pointer);
    t_single();
    t_incr();
    t_burst();
    t_stall();
    t_three();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// *** core/skid_buffer.sv ***
// two-entry valid/ready buffer for register write words
`timescale 1ns/100ps
`default_nettype none
module skid_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input  wire logic             i_clk,    // system clock
  input  wire logic             i_rst,    // sync reset
  input  wire logic             i_valid,  // fill side valid
  output logic                  o_ready,  // fill side ready
  input  wire logic [WIDTH-1:0] i_data,   // fill side word
  output logic                  o_valid,  // drain side valid
  input  wire logic             i_ready,  // drain side ready
  output logic      [WIDTH-1:0] o_data    // drain side word
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  assign o_ready = (count != (PW+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign o_data  = mem[rd_ptr];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  a_no_overflow: assert property (@(posedge i_clk) disable iff (i_rst)
    count <= (PW+1)'(DEPTH)) else $error("buffer count beyond depth");
endmodule
`default_nettype wire

// *** core/spi_cmd_pkg.sv ***
// constants shared by the spi register command slave
package spi_cmd_pkg;
  localparam int          BYTE_W        = 8;
  localparam int          ADDR_W        = 8;
  localparam logic [2:0]  OP_SET_ADDR   = 3'h0;
  localparam logic [2:0]  OP_WRITE      = 3'h2;
  localparam logic [2:0]  OP_WRITE_INC  = 3'h3;
  localparam logic [2:0]  OP_READ       = 3'h4;
  localparam logic [2:0]  OP_READ_INC   = 3'h5;
  localparam logic [7:0]  OP_BURST      = 8'hE0;
  localparam logic [7:0]  ADDR_RESET    = 8'h00;
  localparam logic        THREE_WIRE_RESET = 1'b0;
  localparam int          BUF_DEPTH     = 2;

  typedef enum logic [2:0] {
    ST_CMD,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_BURST_ADDR,
    ST_BURST_DATA,
    ST_IDLE
  } phase_t;
endpackage

// *** core/spi_register_command_slave.sv ***
// spi slave that turns instruction bytes into register reads and writes
// How it works
// R01 - burst ends when chip select rises
// R02 - burst accepts unlimited data bytes
// R03 - burst address wraps 255 to 0
// R04 - set address then write or read
// R05 - increment instructions advance pointer after the write byte, or at the first falling edge of the read byte
// R06 - burst byte two is start address
// R07 - no burst read; use read increment
// R08 - msb first, instruction first after select
// R09 - decode 000 set, 010 write, 100 read
// R10 - 011/101 increment, E0 burst write
// R11 - select bit picks 4-wire or 3-wire
`timescale 1ns/100ps
`default_nettype none
module spi_register_command_slave
  import spi_cmd_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic              i_clk,                 // 125 MHz system clock
  input  wire logic              i_rst,                 // sync reset, active high
  input  wire logic              i_sclk,                // serial clock from host
  input  wire logic              i_chip_select_low,     // chip select, active low
  input  wire logic              i_sdi,                 // 4-wire data in
  output logic                   o_sdo,                 // 4-wire data out
  output logic                   o_sdo_oe,              // 4-wire data out enable
  input  wire logic              i_sdio,                // 3-wire data in
  output logic                   o_sdio,                // 3-wire data out
  output logic                   o_sdio_oe,             // 3-wire drive enable
  input  wire logic              i_three_wire_select,   // 1 selects 3-wire
  output logic                   o_wr_valid,            // register write valid
  input  wire logic              i_wr_ready,            // register write ready
  output logic      [ADDR_W-1:0] o_wr_addr,             // register write address
  output logic      [BYTE_W-1:0] o_wr_data,             // register write data
  output logic                   o_rd_req,              // register read request pulse
  output logic      [ADDR_W-1:0] o_rd_addr,             // register read address
  input  wire logic [BYTE_W-1:0] i_rd_data,             // read data, valid one cycle after request
  output logic      [ADDR_W-1:0] o_pointer,             // current address pointer
  output logic                   o_overrun              // write lost, buffer full
);
  // ==========================================================
  // pin synchronisers
  logic [1:0] sclk_s;
  logic [1:0] cs_s;
  logic [1:0] sdi_s;
  logic [1:0] sdio_s;
  logic       sclk_d;
  logic       three_wire;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sclk_s <= 2'h0;
      cs_s   <= 2'h3;
      sdi_s  <= 2'h0;
      sdio_s <= 2'h0;
      sclk_d <= 1'b0;
    end else begin
      sclk_s <= {sclk_s[0], i_sclk};
      cs_s   <= {cs_s[0], i_chip_select_low};
      sdi_s  <= {sdi_s[0], i_sdi};
      sdio_s <= {sdio_s[0], i_sdio};
      sclk_d <= sclk_s[1];
    end
  end

  // mode bit taken only while the link is idle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      three_wire <= THREE_WIRE_RESET;
    end else if (cs_s[1]) begin
      three_wire <= i_three_wire_select; // R11
    end
  end

  logic selected;
  logic rise;
  logic fall;
  logic din;
  assign selected = !cs_s[1];
  assign rise     = selected && sclk_s[1] && !sclk_d;
  assign fall     = selected && !sclk_s[1] && sclk_d;
  assign din      = three_wire ? sdio_s[1] : sdi_s[1]; // R11

  // ==========================================================
  // shift register
  logic [BYTE_W-1:0] shift;
  logic [2:0]        bit_cnt;
  logic              byte_done;
  logic [BYTE_W-1:0] rx_byte;

  assign rx_byte   = {shift[BYTE_W-2:0], din};
  assign byte_done = rise && (bit_cnt == 3'h7);

  always_ff @(posedge i_clk) begin
    if (i_rst || !selected) begin
      bit_cnt <= 3'h0;
      shift   <= 8'h00;
    end else if (rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      shift   <= rx_byte; // R08
    end
  end

  // ==========================================================
  // instruction sequencer
  phase_t            phase;
  logic [ADDR_W-1:0] pointer;
  logic              inc_after;
  logic              wr_push;
  logic              wr_ready_in;
  logic              rd_done;

  assign o_pointer = pointer;

  always_ff @(posedge i_clk) begin
    if (i_rst || !selected) begin
      phase     <= ST_CMD; // R01 R08
      inc_after <= 1'b0;
    end else if (byte_done) begin
      case (phase)
        ST_CMD: begin
          inc_after <= 1'b0;
          if (rx_byte == OP_BURST) begin
            phase <= ST_BURST_ADDR; // R10
          end else begin
            case (rx_byte[7:5])
              OP_SET_ADDR: begin
                phase <= ST_ADDR; // R09
              end
              OP_WRITE: begin
                phase <= ST_WDATA; // R04
              end
              OP_WRITE_INC: begin
                phase     <= ST_WDATA; // R10
                inc_after <= 1'b1;
              end
              OP_READ: begin
                phase <= ST_RDATA; // R09
              end
              OP_READ_INC: begin
                phase     <= ST_RDATA; // R07 R10
                inc_after <= 1'b1;
              end
              default: begin
                phase <= ST_IDLE;
              end
            endcase
          end
        end
        ST_BURST_ADDR: begin
          phase <= ST_BURST_DATA; // R06
        end
        ST_BURST_DATA: begin
          phase <= ST_BURST_DATA; // R02
        end
        default: begin
          phase <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pointer <= ADDR_RESET;
    end else if (byte_done) begin
      case (phase)
        ST_ADDR, ST_BURST_ADDR: begin
          pointer <= rx_byte; // R04 R06
        end
        ST_WDATA: begin
          if (inc_after) begin
            pointer <= pointer + 8'h01; // R05
          end
        end
        ST_BURST_DATA: begin
          pointer <= pointer + 8'h01; // R03
        end
        default: begin
          pointer <= pointer;
        end
      endcase
    end else if (fall && phase == ST_RDATA && bit_cnt == 3'h0 && inc_after && rd_done) begin
      pointer <= pointer + 8'h01; // R05
    end
  end

  // ==========================================================
  // write path through buffer
  logic [ADDR_W+BYTE_W-1:0] wr_word;
  assign wr_push = byte_done && (phase == ST_WDATA || phase == ST_BURST_DATA); // R02
  assign {o_wr_addr, o_wr_data} = wr_word;

  skid_buffer #(
    .WIDTH (ADDR_W + BYTE_W),
    .DEPTH (DEPTH)
  ) u_wbuf (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_valid (wr_push),
    .o_ready (wr_ready_in),
    .i_data  ({pointer, rx_byte}),
    .o_valid (o_wr_valid),
    .i_ready (i_wr_ready),
    .o_data  (wr_word)
  );

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_overrun <= 1'b0;
    end else begin
      o_overrun <= wr_push && !wr_ready_in;
    end
  end

  // ==========================================================
  // read path
  logic              rd_wait;
  logic [BYTE_W-1:0] tx;

  assign o_rd_addr = pointer;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rd_req <= 1'b0;
      rd_wait  <= 1'b0;
    end else begin
      o_rd_req <= byte_done && phase == ST_CMD && rx_byte != OP_BURST
                  && (rx_byte[7:5] == OP_READ || rx_byte[7:5] == OP_READ_INC);
      rd_wait  <= o_rd_req;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || !selected) begin
      rd_done <= 1'b0;
    end else if (rd_wait) begin
      rd_done <= 1'b1;
    end else if (byte_done) begin
      rd_done <= 1'b0;
    end
  end

  // msb driven first, shifted on each falling edge of the byte except the first
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx <= 8'h00;
    end else if (rd_wait) begin
      tx <= i_rd_data; // R08
    end else if (fall && phase == ST_RDATA && bit_cnt != 3'h0) begin
      tx <= {tx[BYTE_W-2:0], 1'b0};
    end
  end

  logic drive;
  assign drive = selected && phase == ST_RDATA && rd_done;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sdo     <= 1'b0;
      o_sdo_oe  <= 1'b0;
      o_sdio    <= 1'b0;
      o_sdio_oe <= 1'b0;
    end else begin
      o_sdo     <= tx[BYTE_W-1];
      o_sdio    <= tx[BYTE_W-1];
      o_sdo_oe  <= drive && !three_wire; // R11
      o_sdio_oe <= drive && three_wire;
    end
  end

  // ==========================================================
  // checks
  a_burst_wrap: assert property (@(posedge i_clk) disable iff (i_rst)
    (byte_done && phase == ST_BURST_DATA && pointer == 8'hFF) |=> pointer == 8'h00) // R03
    else $error("burst pointer did not wrap");
  a_cs_ends: assert property (@(posedge i_clk) disable iff (i_rst)
    !selected |=> phase == ST_CMD && !wr_push) // R01
    else $error("frame state kept after deselect");
  a_set_addr: assert property (@(posedge i_clk) disable iff (i_rst)
    (byte_done && (phase == ST_ADDR || phase == ST_BURST_ADDR)) |=> pointer == $past(rx_byte)) // R04
    else $error("address byte not loaded");
  a_burst_entry: assert property (@(posedge i_clk) disable iff (i_rst)
    (byte_done && phase == ST_CMD && rx_byte == 8'hE0) |=> phase == ST_BURST_ADDR) // R10
    else $error("burst code not decoded");
  a_burst_stays: assert property (@(posedge i_clk) disable iff (i_rst)
    (byte_done && phase == ST_BURST_DATA) |=> phase == ST_BURST_DATA) // R02
    else $error("burst left early");
  a_winc_step: assert property (@(posedge i_clk) disable iff (i_rst)
    (byte_done && phase == ST_WDATA && inc_after) |=> pointer == $past(pointer) + 8'h01) // R05
    else $error("write increment missed");
  a_read_req: assert property (@(posedge i_clk) disable iff (i_rst)
    (byte_done && phase == ST_CMD && rx_byte[7:5] == 3'h4) |=> o_rd_req ##1 rd_wait) // R09
    else $error("read not requested");
  a_mode_pins: assert property (@(posedge i_clk) disable iff (i_rst)
    !(o_sdo_oe && o_sdio_oe)) // R11
    else $error("both data outputs enabled");
endmodule
`default_nettype wire
